// *** rtl/ptfc_pkg.sv ***
// package: offsets, reset values, field positions and carriers of the processor fan config bank
package ptfc_pkg;

  localparam logic [7:0] FAN_ONE_MAX_OFS   = 8'h38;
  localparam logic [7:0] FAN_TWO_MAX_OFS   = 8'h39;
  localparam logic [7:0] FAN_THREE_MAX_OFS = 8'h3a;
  localparam logic [7:0] START_TEMP_OFS    = 8'h3b;
  localparam logic [7:0] SPAN_RAMP_OFS     = 8'h3c;
  localparam logic [7:0] READING_CFG_OFS   = 8'h8a;

  localparam logic [7:0] MAX_DUTY_RST      = 8'hff;
  localparam logic [7:0] START_TEMP_RST    = 8'he0;
  localparam logic [7:0] SPAN_RAMP_RST     = 8'hc0;
  localparam logic [7:0] READING_CFG_RST   = 8'h00;

  // reading config fields
  localparam int AVG_LSB     = 0;
  localparam int DOMAIN_BIT  = 3;
  localparam int SWAP_BIT    = 4;
  localparam logic [7:0] READING_CFG_WMASK = 8'h1f;

  // span/ramp fields
  localparam int RAMP_LSB    = 0;
  localparam int ACOUS_EN_BIT = 3;

  localparam int NUM_FANS    = 3;

  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic [7:0] wdata;
  } ptfc_reg_req_s;

  typedef struct packed {
    logic [NUM_FANS-1:0][7:0] max_duty;
    logic [7:0]               start_temp;
    logic [7:0]               span_ramp;
    logic [7:0]               reading_cfg;
    logic [NUM_FANS-1:0][7:0] duty;
    logic [7:0]               rdata;
    logic [7:0]               remote1_shown;
    logic [7:0]               processor_shown;
    logic                     above_start;
    logic [16:0]              average_count;
  } ptfc_state_s;

endpackage

// *** rtl/ptfc_regs.sv ***
// processor fan configuration register bank with swap, clamp and acoustic ramp
// What this block does
// R1: averaging field picks 16 to 65536 processor readings; code 111 reserved.
// R2: domain-count bit 3 resets 0 for single domain, 1 means two domains.
// R3: swap bit 4 exchanges remote 1 and processor readings as shown.
// R4: swap also exchanges limit and fan registers; software programs matching format. This block only drives the bit out on o_channel_swap.
// R5: with lock set, writes to these registers are ignored.
// R6: three max-duty registers reset to ff, meaning full duty.
// R7: each fan's automatic duty is clamped to its max-duty register.
// R8: processor reading above start temperature starts fans at minimum duty, then slope.
// R9: start temperature resets to e0, minus 32 processor-relative.
// R10: enhanced acoustics ramps duty gradually at ramp field rate.
// R11: ramp step scales with round-robin tick; code 111 fastest.
// R12: span and ramp register resets to c0.
`timescale 1ns/10ps

module ptfc_regs (
  input  wire logic                               i_clock,
  input  wire logic                               i_rst,
  input  wire ptfc_pkg::ptfc_reg_req_s            i_reg_req,
  input  wire logic                               i_lock,
  input  wire logic [7:0]                         i_remote1_temp,
  input  wire logic [7:0]                         i_first_processor_reading,
  input  wire logic [7:0]                         i_minimum_duty,
  input  wire logic [ptfc_pkg::NUM_FANS-1:0][7:0] i_auto_duty,
  input  wire logic                               i_round_robin_tick,
  output logic      [7:0]                         o_reg_rdata,
  output logic      [7:0]                         o_remote1_shown,
  output logic      [7:0]                         o_processor_shown,
  output logic                                    o_channel_swap,
  output logic                                    o_cpu_domain_count_bit,
  output logic      [16:0]                        o_average_count,
  output logic                                    o_above_start,
  output logic      [ptfc_pkg::NUM_FANS-1:0][7:0] o_fan_duty,
  output logic      [7:0]                         o_temperature_span
);

  ////////////////////////////////////////////////////////////////////////////
  // decoders

  function automatic logic [16:0] avg_count(input logic [2:0] code);
    unique case (code)
      3'h0:    avg_count = 17'h00010;
      3'h1:    avg_count = 17'h00800;
      3'h2:    avg_count = 17'h01000;
      3'h3:    avg_count = 17'h02000;
      3'h4:    avg_count = 17'h04000;
      3'h5:    avg_count = 17'h08000;
      3'h6:    avg_count = 17'h10000;
      default: avg_count = 17'h00000; // reserved code reads as no count
    endcase
  endfunction

  // duty units moved per round-robin cycle; full scale ff takes 255/step cycles
  function automatic logic [7:0] ramp_step(input logic [2:0] code);
    unique case (code)
      3'h0: ramp_step = 8'h01;
      3'h1: ramp_step = 8'h02;
      3'h2: ramp_step = 8'h03;
      3'h3: ramp_step = 8'h04;
      3'h4: ramp_step = 8'h08;
      3'h5: ramp_step = 8'h0c;
      3'h6: ramp_step = 8'h18;
      3'h7: ramp_step = 8'h30;
    endcase
  endfunction

  function automatic logic [7:0] move_toward(input logic [7:0] cur,
                                             input logic [7:0] tgt,
                                             input logic [7:0] step);
    logic [8:0] up;
    logic [8:0] dn;
    up = {1'b0, cur} + {1'b0, step};
    dn = {1'b0, cur} - {1'b0, step};
    if (tgt > cur) begin
      move_toward = (up[8] || up[7:0] > tgt) ? tgt : up[7:0];
    end else if (tgt < cur) begin
      move_toward = (dn[8] || dn[7:0] < tgt) ? tgt : dn[7:0];
    end else begin
      move_toward = cur;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  ptfc_pkg::ptfc_state_s state_reg;
  ptfc_pkg::ptfc_state_s state_next;

  logic       swap;
  logic       acous_en;
  logic [7:0] target;
  logic [7:0] demand;

  always_comb begin
    state_next = state_reg;
    swap       = state_reg.reading_cfg[ptfc_pkg::SWAP_BIT];
    acous_en   = state_reg.span_ramp[ptfc_pkg::ACOUS_EN_BIT];
    target     = 8'h00;
    demand     = 8'h00;

    // lock turns the bank read-only; the write is dropped silently
    if (i_reg_req.wr && !i_lock) begin // [R5]
      unique case (i_reg_req.addr)
        ptfc_pkg::FAN_ONE_MAX_OFS:   state_next.max_duty[0] = i_reg_req.wdata; // [R6]
        ptfc_pkg::FAN_TWO_MAX_OFS:   state_next.max_duty[1] = i_reg_req.wdata; // [R6]
        ptfc_pkg::FAN_THREE_MAX_OFS: state_next.max_duty[2] = i_reg_req.wdata; // [R6]
        ptfc_pkg::START_TEMP_OFS:    state_next.start_temp  = i_reg_req.wdata;
        ptfc_pkg::SPAN_RAMP_OFS:     state_next.span_ramp   = i_reg_req.wdata;
        ptfc_pkg::READING_CFG_OFS: begin
          // bits 7:5 reserved, hold zero
          state_next.reading_cfg = i_reg_req.wdata & ptfc_pkg::READING_CFG_WMASK; // [R2]
        end
        default: ;
      endcase
    end

    unique case (i_reg_req.addr)
      ptfc_pkg::FAN_ONE_MAX_OFS:   state_next.rdata = state_reg.max_duty[0];
      ptfc_pkg::FAN_TWO_MAX_OFS:   state_next.rdata = state_reg.max_duty[1];
      ptfc_pkg::FAN_THREE_MAX_OFS: state_next.rdata = state_reg.max_duty[2];
      ptfc_pkg::START_TEMP_OFS:    state_next.rdata = state_reg.start_temp;
      ptfc_pkg::SPAN_RAMP_OFS:     state_next.rdata = state_reg.span_ramp;
      ptfc_pkg::READING_CFG_OFS:   state_next.rdata = state_reg.reading_cfg;
      default:                     state_next.rdata = 8'h00;
    endcase

    // channel exchange; limit and fan registers follow via o_channel_swap
    state_next.remote1_shown   = swap ? i_first_processor_reading : i_remote1_temp; // [R3] [R4]
    state_next.processor_shown = swap ? i_remote1_temp : i_first_processor_reading; // [R3] [R4]

    state_next.average_count =
      avg_count(state_reg.reading_cfg[ptfc_pkg::AVG_LSB +: 3]); // [R1]

    // both values are two's complement in processor-relative format
    state_next.above_start =
      $signed(state_next.processor_shown) > $signed(state_reg.start_temp); // [R8] [R9]

    for (int f = 0; f < ptfc_pkg::NUM_FANS; f++) begin
      // below start the demand is zero; above, it never drops under minimum
      if (!state_reg.above_start) begin
        demand = 8'h00;
      end else if (i_auto_duty[f] < i_minimum_duty) begin
        demand = i_minimum_duty; // [R8]
      end else begin
        demand = i_auto_duty[f]; // [R8]
      end
      target = (demand > state_reg.max_duty[f]) ? state_reg.max_duty[f] : demand; // [R7]
      if (!acous_en) begin
        state_next.duty[f] = target;
      end else if (i_round_robin_tick) begin
        // one step per round-robin cycle, so ramp time tracks that cycle
        state_next.duty[f] = move_toward(state_reg.duty[f], target,
          ramp_step(state_reg.span_ramp[ptfc_pkg::RAMP_LSB +: 3])); // [R10] [R11]
      end else if (state_reg.duty[f] > state_reg.max_duty[f]) begin
        state_next.duty[f] = state_reg.max_duty[f]; // [R7]
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      state_reg                 <= '0;
      state_reg.max_duty[0]     <= ptfc_pkg::MAX_DUTY_RST; // [R6]
      state_reg.max_duty[1]     <= ptfc_pkg::MAX_DUTY_RST; // [R6]
      state_reg.max_duty[2]     <= ptfc_pkg::MAX_DUTY_RST; // [R6]
      state_reg.start_temp      <= ptfc_pkg::START_TEMP_RST; // [R9]
      state_reg.span_ramp       <= ptfc_pkg::SPAN_RAMP_RST; // [R12]
      state_reg.reading_cfg     <= ptfc_pkg::READING_CFG_RST; // [R2]
      state_reg.average_count   <= 17'h00010;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all straight from state_reg

  assign o_reg_rdata            = state_reg.rdata;
  assign o_remote1_shown        = state_reg.remote1_shown;
  assign o_processor_shown      = state_reg.processor_shown;
  assign o_channel_swap         = state_reg.reading_cfg[ptfc_pkg::SWAP_BIT];
  assign o_cpu_domain_count_bit = state_reg.reading_cfg[ptfc_pkg::DOMAIN_BIT];
  assign o_average_count        = state_reg.average_count;
  assign o_above_start          = state_reg.above_start;
  assign o_fan_duty             = state_reg.duty;
  assign o_temperature_span     = state_reg.span_ramp;

endmodule // ptfc_regs

// *** verification/ptfc_regs_chk.sv ***
// concurrent checks on the processor fan config bank ports
`timescale 1ns/10ps
module ptfc_regs_chk (
  input wire logic                               i_clock,
  input wire logic                               i_rst,
  input wire ptfc_pkg::ptfc_reg_req_s            i_reg_req,
  input wire logic                               i_lock,
  input wire logic [7:0]                         i_first_processor_reading,
  input wire logic                               i_round_robin_tick,
  input wire logic [7:0]                         o_reg_rdata,
  input wire logic [7:0]                         o_remote1_shown,
  input wire logic [7:0]                         o_processor_shown,
  input wire logic                               o_channel_swap,
  input wire logic                               o_cpu_domain_count_bit,
  input wire logic [16:0]                        o_average_count,
  input wire logic                               o_above_start,
  input wire logic [ptfc_pkg::NUM_FANS-1:0][7:0] o_fan_duty,
  input wire logic [7:0]                         o_temperature_span
);
  // step per tick by ramp code, code 0 rightmost
  localparam logic [7:0][5:0] STEPS = {6'h30, 6'h18, 6'h0c, 6'h08, 6'h04, 6'h03, 6'h02, 6'h01};
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  a_swap_shown: assert property (o_channel_swap |=> o_remote1_shown == $past(i_first_processor_reading))
    else $error("remote 1 view not swapped");
  a_std_shown: assert property (!o_channel_swap |=> o_processor_shown == $past(i_first_processor_reading))
    else $error("processor view wrong in standard mode");
  a_ramp_hold: assert property (o_temperature_span[3] && !i_round_robin_tick && !i_reg_req.wr |=> o_fan_duty[0] <= $past(o_fan_duty[0]))
    else $error("duty rose between ramp ticks");
  a_ramp_rate: assert property (o_temperature_span[3] && i_round_robin_tick && !i_reg_req.wr |=> 9'(o_fan_duty[0]) <= 9'($past(o_fan_duty[0])) + 9'(STEPS[$past(o_temperature_span[2:0])]))
    else $error("duty rose faster than ramp step");
  a_span_write: assert property (!i_lock && i_reg_req.wr && i_reg_req.addr == ptfc_pkg::SPAN_RAMP_OFS |=> o_temperature_span == $past(i_reg_req.wdata))
    else $error("span and ramp write lost");
  a_span_readback: assert property (i_reg_req.addr == ptfc_pkg::SPAN_RAMP_OFS |=> o_reg_rdata == $past(o_temperature_span))
    else $error("span and ramp read data wrong");
  a_lock_hold: assert property (i_lock && i_reg_req.wr |=> $stable(o_temperature_span) && $stable(o_cpu_domain_count_bit))
    else $error("write took effect while locked");
  a_avg_legal: assert property (o_average_count inside {17'h00000, 17'h00010, 17'h00800, 17'h01000, 17'h02000, 17'h04000, 17'h08000, 17'h10000})
    else $error("illegal averaging count");
  a_idle_below: assert property (!o_above_start && !o_temperature_span[3] |=> o_fan_duty[0] == 8'h00)
    else $error("fan driven while below start temperature");
  c_swap: cover property (o_channel_swap);
  c_locked_write: cover property (i_lock && i_reg_req.wr);
  c_ramp_tick: cover property (o_temperature_span[3] && i_round_robin_tick);
endmodule // ptfc_regs_chk
bind ptfc_regs ptfc_regs_chk u_chk (.*);

// *** verification/ptfc_regs_bench.sv ***
// self-checking bench for the processor fan config bank
`timescale 1ns/10ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin num_errors++; $display("MISMATCH %0s exp %h got %h", n, e, g); end end
module ptfc_regs_bench;
  logic                    i_clock, i_rst, i_lock, i_round_robin_tick, chk_v;
  logic                    o_channel_swap, o_cpu_domain_count_bit, o_above_start;
  ptfc_pkg::ptfc_reg_req_s i_reg_req;
  logic [7:0]              i_remote1_temp, i_first_processor_reading, i_minimum_duty, o_reg_rdata;
  logic [7:0]              o_remote1_shown, o_processor_shown, o_temperature_span, v, p, r;
  logic [2:0][7:0]         i_auto_duty, o_fan_duty;
  logic [16:0]             o_average_count, e, g;
  logic [16:0]             val_q[$];
  int                      sel_q[$];
  int                      num_errors = 0, compares = 0, s, seed = 91;
  string                   nm[6] = '{"rdata", "remote1", "processor", "average", "duty0", "above"};
  logic [7:0]              ofs[6] = '{8'h38, 8'h39, 8'h3a, 8'h3b, 8'h3c, 8'h8a};
  logic [7:0]              rst_v[6] = '{8'hff, 8'hff, 8'hff, 8'he0, 8'hc0, 8'h00};
  logic [16:0]             reading_average_select[8] = '{17'h10, 17'h800, 17'h1000, 17'h2000, 17'h4000, 17'h8000, 17'h10000, 17'h0};
  ptfc_regs dut (.*);
  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end
  task automatic give_verdict;
    if (num_errors == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clock) i_reg_req <= '{a, 1'b1, d};
    @(posedge i_clock) i_reg_req.wr <= 1'b0;
  endtask
  // note the expectation, then flag the cycle it must show in
  task automatic see(input int sl, input logic [16:0] ev, input int n);
    repeat (n) @(posedge i_clock);
    sel_q.push_back(sl);
    val_q.push_back(ev);
    chk_v <= 1'b1;
    @(posedge i_clock) chk_v <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [16:0] ev);
    @(posedge i_clock) i_reg_req.addr <= a;
    see(0, ev, 1);
  endtask
  task automatic tick;
    @(posedge i_clock) i_round_robin_tick <= 1'b1;
    @(posedge i_clock) i_round_robin_tick <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  always @(negedge i_clock) if (chk_v) begin
    s = sel_q.pop_front();
    e = val_q.pop_front();
    g = s == 0 ? 17'(o_reg_rdata) : s == 1 ? 17'(o_remote1_shown) : s == 2 ? 17'(o_processor_shown)
      : s == 3 ? o_average_count : s == 4 ? 17'(o_fan_duty[0]) : 17'(o_above_start);
    `CHK(nm[s], e, g)
  end
  initial begin
    repeat (20000) @(posedge i_clock);
    num_errors++;
    give_verdict();
  end
  initial begin
    i_rst = 1'b1;
    i_lock = 1'b0;
    i_round_robin_tick = 1'b0;
    chk_v = 1'b0;
    i_reg_req = '0;
    i_remote1_temp = 8'h11;
    i_first_processor_reading = 8'h00;
    i_minimum_duty = 8'h20;
    i_auto_duty = '0;
    repeat (8) @(posedge i_clock);
    i_rst <= 1'b0;
    for (int k = 0; k < 6; k++) rd(ofs[k], 17'(rst_v[k]));
    rd(8'h50, 17'h0);
    for (int k = 0; k < 3; k++) begin
      v = 8'($random(seed));
      wr(ofs[k], v);
      rd(ofs[k], 17'(v));
    end
    // random upper bits, swap kept off, every averaging code
    for (int k = 0; k < 8; k++) begin
      v = {3'($random(seed)), 1'b0, 1'($random(seed)), 3'(k)};
      wr(8'h8a, v);
      rd(8'h8a, 17'(v & 8'h1f));
      see(3, reading_average_select[k], 1);
    end
    p = 8'($random(seed));
    r = 8'($random(seed));
    wr(8'h8a, 8'h10);
    i_first_processor_reading <= p;
    i_remote1_temp <= r;
    see(1, 17'(p), 3);
    see(2, 17'(r), 1);
    wr(8'h8a, 8'h00);
    see(2, 17'(p), 3);
    i_lock <= 1'b1;
    wr(8'h3b, 8'h55);
    rd(8'h3b, 17'he0);
    i_lock <= 1'b0;
    wr(8'h38, 8'h70);
    i_auto_duty <= {3{8'h90}};
    i_first_processor_reading <= 8'h10;
    see(4, 17'h70, 4);
    see(5, 17'h1, 1);
    i_auto_duty <= {3{8'h05}};
    see(4, 17'h20, 4);
    i_first_processor_reading <= 8'hc0;
    see(4, 17'h0, 4);
    see(5, 17'h0, 1);
    wr(8'h38, 8'hff);
    wr(8'h3c, 8'hcd);
    i_auto_duty <= {3{8'hff}};
    i_first_processor_reading <= 8'h10;
    see(4, 17'h0, 4);
    repeat (3) tick();
    see(4, 17'h24, 2);
    give_verdict();
  end
endmodule // ptfc_regs_bench
